// ---- lscd_ctrl_decode.sv ----
// Decoding of the nine control bits into mode and pin duties.
// Pure combinational; the caller registers whatever it drives out.
`timescale 1ns/100ps
module lscd_ctrl_decode
(
    input  wire logic [lscd_pkg::CTRL_BITS-1:0]  ctrl,
    output logic                                 sleep,
    output logic [lscd_pkg::SCAN_LINES-1:0]      scan_levels,
    output logic [1:0]                           pin_seg,
    output logic [lscd_pkg::PORTS-1:0]           port_mode,
    output logic                                 blank,
    output logic                                 bias_half
);

    // ========================================================
    // Port-select code to cumulative port mask
    function automatic logic [3:0] port_mask(input logic [2:0] code);
        logic [3:0] m;
        m = 4'h0;
        if (code <= lscd_pkg::PORT_CODE_MAX)
            m = 4'((5'h01 << code) - 5'h01);
        return m;
    endfunction

    wire sleep_sel_a    = ctrl[lscd_pkg::F_SLEEP_A];
    wire sleep_sel_b    = ctrl[lscd_pkg::F_SLEEP_B];
    wire scan_pin_sel_a = ctrl[lscd_pkg::F_SCAN_A];
    wire scan_pin_sel_b = ctrl[lscd_pkg::F_SCAN_B];
    wire [2:0] port_code = {ctrl[lscd_pkg::F_PORT_A],
                            ctrl[lscd_pkg::F_PORT_B],
                            ctrl[lscd_pkg::F_PORT_C]};

    assign sleep     = sleep_sel_a | sleep_sel_b;
    // Standby levels, line six in the top bit
    assign scan_levels = (sleep_sel_a == sleep_sel_b) ? 6'h3f :
                         sleep_sel_b ? 6'h20 : 6'h30;
    assign pin_seg   = scan_pin_sel_a ? 2'h3 :
                       scan_pin_sel_b ? 2'h1 : 2'h0;
    assign port_mode = port_mask(port_code);
    assign blank     = ctrl[lscd_pkg::F_BLANK];
    assign bias_half = ctrl[lscd_pkg::F_BIAS];

endmodule

// ---- lscd_link_master.sv ----
// Controller model for the serial link: frames go out LSB first.
// Assumes the receiver samples link_di on rising link_clk.
`timescale 1ns/100ps
module lscd_link_master
(
    output logic link_clk,
    output logic link_ce,
    output logic link_di
);
    initial
    begin
        link_clk = 1'b0;
        link_ce  = 1'b0;
        link_di  = 1'b1;
    end

    // ========================================
    // Frame sender
    // Clock stands still between frames; nb below 237 makes a short one
    task automatic send(input logic [7:0]   a,
                        input logic [219:0] d,
                        input logic [8:0]   c,
                        input int           nb);
        logic [236:0] f;
        f = {c, d, a};
        #7;
        link_ce = 1'b1;
        for (int i = 0; i < nb; i++)
        begin
            link_di = f[i];
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
        // Released line no longer shows the last bit
        link_di = ~link_di;
        #24 link_ce = 1'b0;
        // Enable stays low a full bit time before any next frame
        #48;
    endtask
endmodule

// ---- lscd_link_rx.sv ----
// Serial link receiver on the link clock.
// Assumes data is sampled on rising link_clk while link_ce is high.
`timescale 1ns/100ps
module lscd_link_rx
#(
    parameter logic [7:0] ADDR = lscd_pkg::LINK_ADDR
)
(
    input  wire logic                            link_clk,
    input  wire logic                            rst_n,
    input  wire logic                            link_ce,
    input  wire logic                            link_di,
    output logic [lscd_pkg::BODY_BITS-1:0]       frame_data,
    output logic                                 frame_tgl
);

    // ========================================================
    // Bit counter
    // Cleared by the frame's own enable, since the clock may stop.
    logic [7:0]                        cnt_reg;
    logic [lscd_pkg::ADDR_BITS-1:0]    addr_reg;
    logic [lscd_pkg::BODY_BITS-1:0]    shift_reg;
    wire                               clr_n    = rst_n & link_ce;
    wire                               in_addr  =
        cnt_reg < 8'(lscd_pkg::ADDR_BITS);
    wire                               last_bit =
        cnt_reg == 8'(lscd_pkg::FRAME_BITS - 1);
    wire                               done     =
        cnt_reg == 8'(lscd_pkg::FRAME_BITS);
    wire [lscd_pkg::BODY_BITS-1:0]     body_next =
        {link_di, shift_reg[lscd_pkg::BODY_BITS-1:1]};

    always_ff @(posedge link_clk or negedge clr_n)
    begin
        if (!clr_n)
            cnt_reg <= 8'h00;
        else if (!done)
            cnt_reg <= cnt_reg + 8'h01;
    end

    always_ff @(posedge link_clk)
    begin
        if (in_addr)
            addr_reg <= {link_di, addr_reg[lscd_pkg::ADDR_BITS-1:1]};
        else if (!done)
            shift_reg <= body_next;
    end

    // ========================================================
    // Completed frame hand-off
    // Only a full frame to our address is published.
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_data <= '0;
            frame_tgl  <= 1'b0;
        end
        else if (link_ce && last_bit && addr_reg == ADDR)
        begin
            frame_data <= body_next;
            frame_tgl  <= ~frame_tgl;
        end
    end

endmodule

// ---- lscd_pkg.sv ----
// Constants shared by the segment control decoder and its helpers.
// Assumes a 229-bit serial frame body: 220 display bits, 9 control bits.
package lscd_pkg;

    // ========================================================
    // Frame layout
    localparam int DISP_BITS  = 220;
    localparam int CTRL_BITS  = 9;
    localparam int ADDR_BITS  = 8;
    localparam int BODY_BITS  = DISP_BITS + CTRL_BITS;
    localparam int FRAME_BITS = ADDR_BITS + BODY_BITS;
    localparam int SEG_COUNT  = 55;
    localparam int COMMONS    = 4;
    localparam int PORTS      = 4;
    localparam int SCAN_LINES = 6;

    // ========================================================
    // Control word field positions
    localparam int F_SLEEP_A = 0;
    localparam int F_SLEEP_B = 1;
    localparam int F_SCAN_A  = 2;
    localparam int F_SCAN_B  = 3;
    localparam int F_PORT_A  = 4;
    localparam int F_PORT_B  = 5;
    localparam int F_PORT_C  = 6;
    localparam int F_BLANK   = 7;
    localparam int F_BIAS    = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL_STAT = 8'h00;
    localparam logic [7:0] REG_CFG       = 8'h04;
    localparam logic [7:0] REG_FRAMES    = 8'h08;
    localparam logic [7:0] REG_DISP0     = 8'h10;
    localparam int         DISP_WORDS    = 7;
    localparam int         CFG_ACCEPT    = 0;
    localparam logic [0:0] CFG_RESET     = 1'h1;
    localparam logic [7:0] LINK_ADDR     = 8'h5a;

    // Port-select count for the cumulative general-purpose ports
    localparam logic [2:0] PORT_CODE_MAX = 3'h4;

endpackage

// ---- lscd_segment_ctrl.sv ----
// Top of the LCD segment control decoder: link frame capture, clock
// crossing, segment/port/scan decode and a Wishbone status slave.
// Assumes the serial link clock is unrelated to ref_clk.
//
// What this block does
// - Both sleep bits zero run; else oscillator, commons, segments stop.
// - Standby scan lines: 00/11 all high, 01 line six, 10 lines five-six.
// - Scan-pin code 00 both scan, 01 first segment, 1x both segment.
// - Port code converts first N shared outputs to ports, N up to four.
// - Port levels come from display bits 1, 5, 9 and 13.
// - Port drives high for a one bit, low for a zero bit.
// - Blank bit zero shows display, one turns all segments off.
// - Blanking drives segment-off levels; commons and oscillator run on.
// - Bias bit zero selects one-third bias, one selects one-half.
// - Segment n takes display bits 4n-3 to 4n for commons one to four.
// - Each display bit lights its own segment and common crossing.
// - Shared pins show display bits only when used as segments.
// - Reset pin low blanks display, stops scanning, still takes frames.
// - Sleep ends only on control data with both sleep bits zero.
// - Port outputs keep following display bits during sleep.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module lscd_segment_ctrl
#(
    parameter logic [7:0] LINK_ADDR = lscd_pkg::LINK_ADDR
)
(
    input  wire logic                               ref_clk,
    input  wire logic                               rst_n,
    input  wire logic                               hw_reset_n,
    input  wire logic                               link_clk,
    input  wire logic                               link_ce,
    input  wire logic                               link_di,
    input  wire logic                               wb_cyc_i,
    input  wire logic                               wb_stb_i,
    input  wire logic                               wb_we_i,
    input  wire logic [7:0]                         wb_adr_i,
    input  wire logic [3:0]                         wb_sel_i,
    input  wire logic [31:0]                        wb_dat_i,
    output logic [31:0]                             wb_dat_o,
    output logic                                    wb_ack_o,
    output logic [lscd_pkg::DISP_BITS-1:0]          seg_on,
    output logic                                    common_run,
    output logic                                    osc_run,
    output logic                                    bias_half,
    output logic [lscd_pkg::SCAN_LINES-1:0]         scan_drive_lines,
    output logic                                    scan_enable,
    output logic [1:0]                              scan_pin_seg,
    output logic [lscd_pkg::PORTS-1:0]              port_mode,
    output logic [lscd_pkg::PORTS-1:0]              port_level
);

    localparam int DB = lscd_pkg::DISP_BITS;
    localparam int CB = lscd_pkg::CTRL_BITS;

    // ========================================================
    // Hardware reset pin synchroniser
    logic hwr_meta_reg;
    logic hwr_sync_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hwr_meta_reg <= 1'b0;
            hwr_sync_reg <= 1'b0;
        end
        else
        begin
            hwr_meta_reg <= hw_reset_n;
            hwr_sync_reg <= hwr_meta_reg;
        end
    end

    // ========================================================
    // Link receiver and frame crossing
    logic [lscd_pkg::BODY_BITS-1:0] frame_data;
    logic                           frame_tgl;
    logic [2:0]                     tgl_sync_reg;

    lscd_link_rx #(.ADDR(LINK_ADDR)) u_rx
    (
        .link_clk   (link_clk),
        .rst_n      (rst_n),
        .link_ce    (link_ce),
        .link_di    (link_di),
        .frame_data (frame_data),
        .frame_tgl  (frame_tgl)
    );

    // Frame data stays still for a whole frame after the toggle,
    // so it is safe to copy once the toggle has been synchronised.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            tgl_sync_reg <= 3'h0;
        else
            tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl};
    end

    logic [0:0]    cfg_reg;
    wire           new_frame  = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    wire           load_frame = new_frame & cfg_reg[lscd_pkg::CFG_ACCEPT];

    // ========================================================
    // Live display and control state
    logic [DB-1:0]  disp_reg;
    logic [CB-1:0]  ctrl_reg;
    logic [31:0]    frames_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            disp_reg   <= '0;
            ctrl_reg   <= lscd_pkg::CTRL_RESET;
            frames_reg <= 32'h0000_0000;
        end
        else if (load_frame)
        begin
            disp_reg   <= frame_data[DB-1:0];
            ctrl_reg   <= frame_data[DB+CB-1:DB];
            frames_reg <= frames_reg + 32'h0000_0001;
        end
    end

    // ========================================================
    // Control decode
    logic                                 dec_sleep;
    logic [lscd_pkg::SCAN_LINES-1:0]      dec_scan;
    logic [1:0]                           dec_pin_seg;
    logic [lscd_pkg::PORTS-1:0]           dec_port;
    logic                                 dec_blank;
    logic                                 dec_bias;

    lscd_ctrl_decode u_dec
    (
        .ctrl        (ctrl_reg),
        .sleep       (dec_sleep),
        .scan_levels (dec_scan),
        .pin_seg     (dec_pin_seg),
        .port_mode   (dec_port),
        .blank       (dec_blank),
        .bias_half   (dec_bias)
    );

    // ========================================================
    // Segment map: bit 4(n-1)+c drives segment n, common c+1
    // Shared outputs that are not segments read as off.
    logic [DB-1:0] seg_mask;
    genvar g;
    generate
        for (g = 0; g < lscd_pkg::SEG_COUNT; g++)
        begin : g_seg
            if (g < lscd_pkg::PORTS)
            begin : g_port
                assign seg_mask[4*g +: 4] = {4{~dec_port[g]}};
            end
            else if (g >= lscd_pkg::SEG_COUNT - 2)
            begin : g_scan
                assign seg_mask[4*g +: 4] =
                    {4{dec_pin_seg[g-(lscd_pkg::SEG_COUNT-2)]}};
            end
            else
            begin : g_plain
                assign seg_mask[4*g +: 4] = 4'hf;
            end
        end
    endgenerate

    // Blanking and reset clear segment levels, reset also drops scan_enable; commons keep
    // running so the panel sees a proper off waveform.
    wire           seg_off    = dec_sleep | dec_blank | ~hwr_sync_reg;
    wire [DB-1:0]  seg_next   =
        seg_off ? '0 : disp_reg & seg_mask;
    wire [3:0]     group_head = {disp_reg[12], disp_reg[8],
                                 disp_reg[4], disp_reg[0]};
    wire [3:0]     port_next  =
        group_head & dec_port;
    wire [5:0]     scan_next  = dec_scan & {4'hf, ~dec_pin_seg};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seg_on           <= '0;
            common_run       <= 1'b0;
            osc_run          <= 1'b0;
            bias_half        <= 1'b0;
            scan_drive_lines <= 6'h00;
            scan_enable      <= 1'b0;
            scan_pin_seg     <= 2'h0;
            port_mode        <= 4'h0;
            port_level       <= 4'h0;
        end
        else
        begin
            seg_on           <= seg_next;
            common_run       <= ~dec_sleep;
            osc_run          <= ~dec_sleep;
            bias_half        <= dec_bias;
            scan_drive_lines <= scan_next;
            scan_enable      <= hwr_sync_reg;
            scan_pin_seg     <= dec_pin_seg;
            port_mode        <= dec_port;
            port_level       <= port_next;
        end
    end

    // ========================================================
    // Wishbone slave: one wait state, unmapped reads give zero
    wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0]  disp_off = wb_adr_i - lscd_pkg::REG_DISP0;
    wire        disp_hit = wb_adr_i >= lscd_pkg::REG_DISP0 &&
                           disp_off[7:2] < 6'(lscd_pkg::DISP_WORDS);
    wire [255:0] disp_ext = {36'h0, disp_reg};
    wire [31:0] disp_word = disp_ext[32*disp_off[4:2] +: 32];
    wire [31:0] stat_word = {21'h0, ~hwr_sync_reg, dec_sleep, ctrl_reg};
    wire [31:0] rd_next   =
        (wb_adr_i == lscd_pkg::REG_CTRL_STAT) ? stat_word :
        (wb_adr_i == lscd_pkg::REG_CFG)       ? {31'h0, cfg_reg} :
        (wb_adr_i == lscd_pkg::REG_FRAMES)    ? frames_reg :
        disp_hit                              ? disp_word : 32'h0;
    wire        cfg_wr   = wb_req & wb_we_i & wb_sel_i[0] &
                           (wb_adr_i == lscd_pkg::REG_CFG);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            cfg_reg  <= lscd_pkg::CFG_RESET;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_next : 32'h0;
            if (cfg_wr)
                cfg_reg <= wb_dat_i[0:0];
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_sleep_stops: assert property (
        ctrl_reg[1:0] != 2'h0 |=> !osc_run && !common_run && seg_on == '0)
        else $error("sleep did not stop outputs");
    chk_normal_runs: assert property (
        ctrl_reg[1:0] == 2'h0 |=> osc_run && common_run)
        else $error("normal mode not running");
    chk_scan_levels: assert property (
        ctrl_reg[3:0] == 4'h2 |=> scan_drive_lines == 6'h20)
        else $error("standby scan levels wrong");
    chk_scan_pins: assert property (
        ctrl_reg[3:2] == 2'h2 |=> scan_pin_seg == 2'h1 &&
        scan_drive_lines[0] == 1'b0)
        else $error("scan pin duty wrong");
    chk_port_count: assert property (
        {ctrl_reg[4], ctrl_reg[5], ctrl_reg[6]} == 3'h3 |=>
        port_mode == 4'h7)
        else $error("port count wrong");
    chk_port_reserved: assert property (
        ctrl_reg[4] && (ctrl_reg[5] || ctrl_reg[6]) |=> port_mode == 4'h0)
        else $error("reserved port code not all segments");
    chk_port_level: assert property (
        port_mode[3] |-> port_level[3] == $past(disp_reg[12]))
        else $error("port level not following display bit");
    chk_blank_keeps: assert property (
        ctrl_reg[7] && ctrl_reg[1:0] == 2'h0 |=>
        seg_on == '0 && common_run && osc_run)
        else $error("blanking stopped commons");
    chk_seg_map: assert property (
        !seg_off && !dec_port[0] |=> seg_on[3:0] == $past(disp_reg[3:0]))
        else $error("segment map wrong");
    chk_hw_reset: assert property (
        !hwr_sync_reg |=> seg_on == '0 && !scan_enable)
        else $error("hardware reset did not blank");
    chk_frame_only: assert property (
        !$stable(disp_reg) |-> $past(load_frame))
        else $error("display changed without a frame");
    chk_scan_five_six: assert property (
        ctrl_reg[3:0] == 4'h1 |=> scan_drive_lines == 6'h30)
        else $error("standby lines five and six wrong");
    chk_scan_both_seg: assert property (
        ctrl_reg[2] |=> scan_pin_seg == 2'h3 &&
        scan_drive_lines[1:0] == 2'h0)
        else $error("shared scan pins not segments");
    chk_port_none: assert property (
        {ctrl_reg[4], ctrl_reg[5], ctrl_reg[6]} == 3'h0 |=>
        port_mode == 4'h0 && port_level == 4'h0)
        else $error("ports active with code zero");
    chk_sleep_ports: assert property (
        ctrl_reg[1:0] != 2'h0 && ctrl_reg[6:4] == 3'h1 |=>
        port_mode == 4'hf && port_level[0] == $past(disp_reg[0]))
        else $error("ports stopped following in sleep");
    chk_bias_follow: assert property (
        ctrl_reg[8] |=> bias_half)
        else $error("half bias not selected");

endmodule

// ---- lscd_segment_ctrl_tb.sv ----
// Self-checking bench for the segment control decoder.
// Assumes the link model drives the serial pins at 48 ns per bit.
`timescale 1ns/100ps
module lscd_segment_ctrl_tb;
    logic          ref_clk, rst_n, hw_reset_n;
    wire logic     link_clk, link_ce, link_di;
    logic          wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]    wb_adr_i;
    logic [3:0]    wb_sel_i;
    logic [31:0]   wb_dat_i, wb_dat_o;
    logic [219:0]  seg_on, cur_d;
    logic          common_run, osc_run, bias_half, scan_enable;
    logic [5:0]    scan_drive_lines;
    logic [1:0]    scan_pin_seg;
    logic [3:0]    port_mode, port_level;
    logic [8:0]    cur_c;
    logic [219:0]  pat;
    int            num_errors, tests_run, frames;

    lscd_segment_ctrl dut (.ref_clk, .rst_n, .hw_reset_n, .link_clk,
        .link_ce, .link_di, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .seg_on, .common_run,
        .osc_run, .bias_half, .scan_drive_lines, .scan_enable,
        .scan_pin_seg, .port_mode, .port_level);
    lscd_link_master u_link (.link_clk, .link_ce, .link_di);

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ========================================
    // Compare, bus and closing tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check_bus(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic check_pin(input logic [219:0] g, input logic [219:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        // Ack and data are taken at the edge that samples ack high
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20)
        begin
            num_errors++;
            final_report();
        end
    endtask

    // Worst case is five edges after the last link bit
    task automatic send(input logic [219:0] d, input logic [8:0] c);
        u_link.send(lscd_pkg::LINK_ADDR, d, c, 237);
        repeat (12) @(posedge ref_clk);
        cur_d = d;
        cur_c = c;
        frames++;
    endtask

    task automatic check_all();
        logic [219:0] m;
        logic [3:0]   pm;
        logic [5:0]   sl;
        logic [1:0]   ps;
        logic [2:0]   pc;
        logic [31:0]  q;
        logic         slp;
        @(negedge ref_clk);
        slp = cur_c[0] | cur_c[1];
        ps = {cur_c[2], cur_c[2] | cur_c[3]};
        pc = {cur_c[4], cur_c[5], cur_c[6]};
        pm = (pc <= 3'h4) ? 4'((5'h1 << pc) - 5'h1) : 4'h0;
        m = cur_d;
        for (int i = 0; i < 4; i++)
            if (pm[i]) m[4*i +: 4] = 4'h0;
        if (!ps[0]) m[212 +: 4] = 4'h0;
        if (!ps[1]) m[216 +: 4] = 4'h0;
        if (slp | cur_c[7] | !hw_reset_n) m = '0;
        sl = (cur_c[1:0] == 2'b10) ? 6'h20 :
             (cur_c[1:0] == 2'b01) ? 6'h30 : 6'h3f;
        sl = sl & ~{4'h0, ps};
        check_pin(seg_on, m);
        check_bus(32'(port_mode), 32'(pm));
        check_bus(32'(port_level), 32'(pm & {cur_d[12], cur_d[8],
                  cur_d[4], cur_d[0]}));
        check_bus(32'(scan_drive_lines), 32'(sl));
        check_bus(32'(scan_pin_seg), 32'(ps));
        check_bus(32'({common_run, osc_run, bias_half, scan_enable}),
                  32'({!slp, !slp, cur_c[8], hw_reset_n}));
        wb(1'b0, 8'h00, 32'h0, q);
        check_bus(q, {21'h0, !hw_reset_n, slp, cur_c});
    endtask

    // ========================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, 8'h04, 32'h0, q);
        check_bus(q, 32'h1);
        wb(1'b0, 8'h40, 32'h0, q);
        check_bus(q, 32'h0);
        wb(1'b1, 8'h00, 32'h1ff, q);
        check_all();
        $display("register test done");
    endtask

    // Walks down through the sleep codes, so only code 0 may wake
    task automatic t_sleep();
        for (int i = 3; i >= 0; i--)
        begin
            send(pat, 9'h010 | 9'(i));
            check_all();
        end
        $display("sleep test done");
    endtask

    task automatic t_pins();
        logic [2:0] k;
        for (int i = 0; i < 4; i++)
        begin
            send(~pat, 9'(i) << 2);
            check_all();
        end
        for (int i = 0; i < 8; i++)
        begin
            k = 3'(i);
            send(pat, {2'b00, k[0], k[1], k[2], 4'hc});
            check_all();
        end
        $display("pin duty test done");
    endtask

    task automatic t_blank();
        logic [31:0] q;
        for (int i = 1; i < 4; i++)
        begin
            send(pat, 9'(i) << 7);
            check_all();
        end
        send(~pat, 9'h00c);
        check_all();
        wb(1'b0, 8'h10, 32'h0, q);
        check_bus(q, cur_d[31:0]);
        wb(1'b0, 8'h28, 32'h0, q);
        check_bus(q, {4'h0, cur_d[219:192]});
        $display("blank and bias test done");
    endtask

    // Wrong address, short frame and a closed gate all leave no trace
    task automatic t_refuse();
        logic [31:0] q;
        u_link.send(8'ha5, pat, 9'h1ff, 237);
        u_link.send(lscd_pkg::LINK_ADDR, pat, 9'h1ff, 236);
        wb(1'b1, 8'h04, 32'h0, q);
        u_link.send(lscd_pkg::LINK_ADDR, pat, 9'h1ff, 237);
        wb(1'b1, 8'h04, 32'h1, q);
        repeat (12) @(posedge ref_clk);
        check_all();
        wb(1'b0, 8'h08, 32'h0, q);
        check_bus(q, 32'(frames));
        $display("refusal test done");
    endtask

    task automatic t_hwres();
        @(posedge ref_clk);
        hw_reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check_all();
        send(pat, 9'h00c);
        check_all();
        @(posedge ref_clk);
        hw_reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check_all();
        $display("device reset test done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        hw_reset_n = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        num_errors = 0;
        tests_run = 0;
        frames = 0;
        cur_d = '0;
        cur_c = 9'h000;
        pat = {11{20'h1c3a5}};
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_regs();
        t_sleep();
        t_pins();
        t_blank();
        t_refuse();
        t_hwres();
        final_report();
    end
endmodule
